// ===== core/clock_frequency_meter.sv
/*
  Clock frequency and time meter with an APB register port.
  Holds the register file, the group multiplexer, the reference counter,
  the measurement sequencer and the clock monitor output.
  Assumes all measured and reference clocks are asynchronous to clk_i and
  are sampled through two flops, so only clocks below half of clk_i are
  counted faithfully.
  // Behaviour
  // - frequency mode clears, then counts over reference window
  // - time mode counts reference cycles while enable active
  // - one to eight channels, one to eight inputs
  // - byte-wide APB writes plus single-cycle access mode
  // - three-bit group field picks the clock group
  // - eight channels per group; unwired inputs ignored
  // - bit 4 picks reference: 0 TCK, 1 PLL
  // - bits 10:8 pick the monitored channel
  // - bit 11 enables the clock monitor output
  // - run length in reference cycles, resets to 10000
  // - two-bit mode per channel: off, frequency, time
  // - reserved mode reads zero count
  // - start bit set by software, cleared at completion
  // - counts hold results once start bit clears
*/
`timescale 1ns/1ps
module clock_frequency_meter #(
  parameter int          NUM_CHANNELS = 8,   // counters, 1 to 8
  parameter int          NUM_GROUPS   = 8,   // inputs per counter, 1 to 8
  parameter logic [63:0] IMPL_MASK    = clock_frequency_meter_pkg::IMPL_MASK_DEFAULT
) (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // apb slave
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [11:0]                    paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  input  wire logic [3:0]                     pstrb_i,
  input  wire logic                           single_cycle_i,
  output logic [31:0]                         prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  // clocks to measure, group-major
  input  wire logic [NUM_GROUPS*NUM_CHANNELS-1:0] meas_clk_i,
  // reference sources and external enable
  input  wire logic                           tck_i,
  input  wire logic                           pll_ref_i,
  input  wire logic                           time_enable_i,
  // monitor and status
  output logic                                monitor_clk_o,
  output logic                                busy_o
);

  localparam int GROUP_W_L = clock_frequency_meter_pkg::GROUP_W;

  // register file
  logic [31:0] clock_select_reg;    // group, reference and monitor choice
  logic [31:0] clock_select_next;
  logic [31:0] run_length_reg;      // window length in reference cycles
  logic [31:0] run_length_next;
  logic [31:0] channel_mode_reg;    // two mode bits per channel
  logic [31:0] channel_mode_next;

  // snapshot of the configuration taken at start
  logic [31:0] snap_select_reg;
  logic [31:0] snap_select_next;
  logic [31:0] snap_run_reg;
  logic [31:0] snap_run_next;
  logic [31:0] snap_mode_reg;
  logic [31:0] snap_mode_next;

  // bus response registers
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // sequencer
  clock_frequency_meter_pkg::meas_state_e state_reg;
  clock_frequency_meter_pkg::meas_state_e state_next;
  logic [31:0] ref_count_reg;       // reference edges seen this run
  logic [31:0] ref_count_next;
  logic        busy_reg;            // reads back as the start bit
  logic        busy_next;
  logic        monitor_reg;
  logic        monitor_next;

  // decode and datapath nets
  logic        access;
  logic        wr_access;
  logic        addr_hit;
  logic [31:0] rdata;
  logic        start_req;
  logic [31:0] sel_eff;             // live config when idle, snapshot when busy
  logic [GROUP_W_L-1:0] group_eff;
  logic        ref_src;
  logic        ref_raw;
  logic        ref_rise;
  logic        time_en;
  logic        chan_clear;
  logic        chan_run;
  logic [NUM_CHANNELS-1:0] chan_raw;
  logic [NUM_CHANNELS-1:0] chan_level;
  logic [NUM_CHANNELS-1:0] chan_rise;
  logic [31:0] count_bus [NUM_CHANNELS];
  logic [11:0] count_off;
  logic [9:0]  count_idx;
  logic [2:0]  mon_chan;

  // merge a write under byte strobes, keeping only implemented bits
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // apb access: classic setup/enable, or one cycle when single_cycle_i
  assign access    = psel_i && (penable_i || single_cycle_i) && !pready_reg;
  assign wr_access = access && pwrite_i;
  assign count_off = paddr_i - clock_frequency_meter_pkg::ADDR_COUNT_BASE;
  assign count_idx = count_off[11:clock_frequency_meter_pkg::WORD_SHIFT];

  // read mux and address decode; unmapped words read zero with an error
  always_comb begin
    rdata    = 32'h0000_0000;
    addr_hit = 1'h1;
    if (paddr_i == clock_frequency_meter_pkg::ADDR_CLOCK_SELECT) begin
      rdata = clock_select_reg;
    end else if (paddr_i == clock_frequency_meter_pkg::ADDR_RUN_LENGTH) begin
      rdata = run_length_reg;
    end else if (paddr_i == clock_frequency_meter_pkg::ADDR_CHANNEL_MODE) begin
      rdata = channel_mode_reg;
    end else if (paddr_i == clock_frequency_meter_pkg::ADDR_MEAS_CONTROL) begin
      rdata[clock_frequency_meter_pkg::START_BIT] = busy_reg;
    end else if (paddr_i >= clock_frequency_meter_pkg::ADDR_COUNT_BASE &&
                 paddr_i[1:0] == 2'h0 && int'(count_idx) < NUM_CHANNELS) begin
      rdata = count_bus[count_idx[2:0]]; // results of the last run
    end else begin
      addr_hit = 1'h0;
    end
  end

  // a start only takes effect when idle; writing zero never aborts
  assign start_req = wr_access && paddr_i == clock_frequency_meter_pkg::ADDR_MEAS_CONTROL &&
                     pstrb_i[0] && pwdata_i[clock_frequency_meter_pkg::START_BIT] &&
                     state_reg == clock_frequency_meter_pkg::ST_IDLE;

  // register file and bus response next values
  always_comb begin
    clock_select_next = clock_select_reg;
    run_length_next   = run_length_reg;
    channel_mode_next = channel_mode_reg;
    pready_next       = access;
    pslverr_next      = access && !addr_hit;
    prdata_next       = prdata_reg;
    if (access && !pwrite_i) begin
      prdata_next = rdata;
    end
    if (wr_access) begin
      // byte lanes honoured on every writable register
      if (paddr_i == clock_frequency_meter_pkg::ADDR_CLOCK_SELECT) begin
        clock_select_next = merge_strb(clock_select_reg, pwdata_i, pstrb_i,
                                       clock_frequency_meter_pkg::CLOCK_SELECT_MASK);
      end
      if (paddr_i == clock_frequency_meter_pkg::ADDR_RUN_LENGTH) begin
        run_length_next = merge_strb(run_length_reg, pwdata_i, pstrb_i, 32'hFFFF_FFFF);
      end
      if (paddr_i == clock_frequency_meter_pkg::ADDR_CHANNEL_MODE) begin
        channel_mode_next = merge_strb(channel_mode_reg, pwdata_i, pstrb_i,
                                       clock_frequency_meter_pkg::CHANNEL_MODE_MASK);
      end
    end
  end

  // register file and bus response registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_select_reg <= clock_frequency_meter_pkg::CLOCK_SELECT_RST; // TCK reference
      run_length_reg   <= clock_frequency_meter_pkg::RUN_LENGTH_RST;
      channel_mode_reg <= clock_frequency_meter_pkg::CHANNEL_MODE_RST;
      pready_reg       <= 1'h0;
      pslverr_reg      <= 1'h0;
      prdata_reg       <= 32'h0000_0000;
    end else begin
      clock_select_reg <= clock_select_next;
      run_length_reg   <= run_length_next;
      channel_mode_reg <= channel_mode_next;
      pready_reg       <= pready_next;
      pslverr_reg      <= pslverr_next;
      prdata_reg       <= prdata_next;
    end
  end

  // while a run is active only the snapshot steers the datapath
  assign sel_eff   = busy_reg ? snap_select_reg : clock_select_reg;
  assign group_eff = sel_eff[clock_frequency_meter_pkg::GROUP_LSB +: GROUP_W_L];
  assign ref_src   = sel_eff[clock_frequency_meter_pkg::REF_SEL_BIT];
  assign mon_chan  = sel_eff[clock_frequency_meter_pkg::MON_CHAN_LSB +: clock_frequency_meter_pkg::MON_CHAN_W];

  // reference source mux ahead of its synchroniser
  assign ref_raw = (ref_src == clock_frequency_meter_pkg::REF_PLL) ? pll_ref_i : tck_i;

  edge_sync u_ref_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ref_raw),
    .level_o (),
    .rise_o  (ref_rise)
  );

  edge_sync u_enable_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (time_enable_i),
    .level_o (time_en),
    .rise_o  ()
  );

  // counters are cleared in the clear state and run inside the window
  assign chan_clear = (state_reg == clock_frequency_meter_pkg::ST_CLEAR);
  assign chan_run   = (state_reg == clock_frequency_meter_pkg::ST_RUN) && (ref_count_reg < snap_run_reg);

  // one counter per channel, each fed by the chosen group's input
  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    logic [NUM_GROUPS-1:0] col;   // this channel's input in every group
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      // unwired group/channel slots are forced low
      assign col[g] = meas_clk_i[g*NUM_CHANNELS+c] & IMPL_MASK[g*NUM_CHANNELS+c];
    end
    assign chan_raw[c] = (int'(group_eff) < NUM_GROUPS) ? col[group_eff] : 1'h0;

    edge_sync u_meas_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (chan_raw[c]),
      .level_o (chan_level[c]),
      .rise_o  (chan_rise[c])
    );

    channel_counter u_counter (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .clear_i     (chan_clear),
      .run_i       (chan_run),
      .mode_i      (snap_mode_reg[c*clock_frequency_meter_pkg::MODE_W +: clock_frequency_meter_pkg::MODE_W]),
      .meas_rise_i (chan_rise[c]),
      .ref_rise_i  (ref_rise),
      .time_en_i   (time_en),
      .count_o     (count_bus[c])
    );
  end

  // sequencer: snapshot on start, clear, run the window, then finish
  always_comb begin
    state_next      = state_reg;
    ref_count_next  = ref_count_reg;
    busy_next       = busy_reg;
    snap_select_next = snap_select_reg;
    snap_run_next   = snap_run_reg;
    snap_mode_next  = snap_mode_reg;
    unique case (state_reg)
      clock_frequency_meter_pkg::ST_IDLE: begin
        if (start_req) begin
          // configuration frozen here, later writes change only the live registers
          snap_select_next = clock_select_reg;
          snap_run_next    = run_length_reg;
          snap_mode_next   = channel_mode_reg;
          busy_next        = 1'h1; // start bit reads one
          state_next       = clock_frequency_meter_pkg::ST_CLEAR;
        end
      end
      clock_frequency_meter_pkg::ST_CLEAR: begin
        ref_count_next = 32'h0000_0000; // every counter cleared first
        state_next     = clock_frequency_meter_pkg::ST_RUN;
      end
      clock_frequency_meter_pkg::ST_RUN: begin
        // window closes on the programmed number of reference edges, counted from entry to run
        if (ref_count_reg >= snap_run_reg) begin
          state_next = clock_frequency_meter_pkg::ST_DONE;
        end else if (ref_rise) begin
          ref_count_next = ref_count_reg + 32'h0000_0001;
        end
      end
      clock_frequency_meter_pkg::ST_DONE: begin
        busy_next  = 1'h0; // start bit falls, counts now final
        state_next = clock_frequency_meter_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg       <= clock_frequency_meter_pkg::ST_IDLE;
      ref_count_reg   <= 32'h0000_0000;
      busy_reg        <= 1'h0;
      snap_select_reg <= clock_frequency_meter_pkg::CLOCK_SELECT_RST;
      snap_run_reg    <= clock_frequency_meter_pkg::RUN_LENGTH_RST;
      snap_mode_reg   <= clock_frequency_meter_pkg::CHANNEL_MODE_RST;
    end else begin
      state_reg       <= state_next;
      ref_count_reg   <= ref_count_next;
      busy_reg        <= busy_next;
      snap_select_reg <= snap_select_next;
      snap_run_reg    <= snap_run_next;
      snap_mode_reg   <= snap_mode_next;
    end
  end

  // monitor copies the synchronised level, so it lags by three cycles
  always_comb begin
    monitor_next = 1'h0;
    if (sel_eff[clock_frequency_meter_pkg::MON_EN_BIT] && int'(mon_chan) < NUM_CHANNELS) begin
      monitor_next = chan_level[mon_chan];
    end
  end

  // monitor register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_reg <= 1'h0;
    end else begin
      monitor_reg <= monitor_next;
    end
  end

  // outputs straight from flops
  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;
  assign monitor_clk_o = monitor_reg;
  assign busy_o        = busy_reg;

endmodule

// ===== pkg/clock_frequency_meter_pkg.sv
/*
  Constants shared by the clock frequency meter: register offsets, field
  positions, reset values, channel modes and measurement states.
  Assumes a 12-bit APB byte address and a 32-bit data path.
*/
package clock_frequency_meter_pkg;

  // bus geometry
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam int          STRB_W            = 4;
  localparam int          WORD_SHIFT        = 2;

  // register byte offsets
  localparam logic [11:0] ADDR_CLOCK_SELECT = 12'h000;
  localparam logic [11:0] ADDR_RUN_LENGTH   = 12'h004;
  localparam logic [11:0] ADDR_CHANNEL_MODE = 12'h008;
  localparam logic [11:0] ADDR_MEAS_CONTROL = 12'h00C;
  localparam logic [11:0] ADDR_COUNT_BASE   = 12'h010;

  // clock_select fields
  localparam int          GROUP_LSB         = 0;
  localparam int          GROUP_W           = 3;
  localparam int          REF_SEL_BIT       = 4;
  localparam int          MON_CHAN_LSB      = 8;
  localparam int          MON_CHAN_W        = 3;
  localparam int          MON_EN_BIT        = 11;
  localparam logic [31:0] CLOCK_SELECT_MASK = 32'h0000_0F17;
  localparam logic [31:0] CLOCK_SELECT_RST  = 32'h0000_0000;

  // run_length
  localparam logic [31:0] RUN_LENGTH_RST    = 32'h0000_2710;

  // channel_mode: two bits per channel in the low half word
  localparam int          MODE_W            = 2;
  localparam logic [31:0] CHANNEL_MODE_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CHANNEL_MODE_RST  = 32'h0000_0000;
  localparam logic [1:0]  MODE_DISABLED     = 2'h0;
  localparam logic [1:0]  MODE_FREQUENCY    = 2'h1;
  localparam logic [1:0]  MODE_RESERVED     = 2'h2;
  localparam logic [1:0]  MODE_TIME         = 2'h3;

  // measure_control
  localparam int          START_BIT         = 0;

  // reference sources
  localparam logic        REF_TCK           = 1'h0;
  localparam logic        REF_PLL           = 1'h1;

  // default map of wired group/channel inputs (groups B to F, two to five channels each)
  localparam logic [63:0] IMPL_MASK_DEFAULT = 64'h0000_0C1F_0F1F_1F00;

  // measurement sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLEAR = 2'b01,
    ST_RUN   = 2'b10,
    ST_DONE  = 2'b11
  } meas_state_e;

endpackage

// ===== core/edge_sync.sv
/*
  Two-flop synchroniser with a rising-edge detector behind it.
  Assumes async_i may toggle at any time relative to clk_i; edges closer
  than two clk_i periods apart are merged.
*/
`timescale 1ns/1ps
module edge_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // asynchronous input
  input  wire logic async_i,
  // synchronised outputs
  output logic      level_o,
  output logic      rise_o
);

  logic meta_reg;   // first stage, read only by the second
  logic sync_reg;   // safe level
  logic prev_reg;   // delayed level for edge detect
  logic meta_next;
  logic sync_next;
  logic prev_next;

  // next values of the chain
  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // register the chain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'h0;
      sync_reg <= 1'h0;
      prev_reg <= 1'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;

endmodule

// ===== core/channel_counter.sv
/*
  One measurement channel counter.
  Assumes clear, run and the edge strobes come from the meter sequencer on
  the same clock; the count is held between measurements.
*/
`timescale 1ns/1ps
module channel_counter (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control from the sequencer
  input  wire logic        clear_i,
  input  wire logic        run_i,
  input  wire logic [1:0]  mode_i,
  // count events
  input  wire logic        meas_rise_i,
  input  wire logic        ref_rise_i,
  input  wire logic        time_en_i,
  // result
  output logic [31:0]      count_o
);

  logic [31:0] count_reg;   // accumulated count
  logic [31:0] count_next;

  // disabled and reserved modes never count, so they read back zero
  always_comb begin
    count_next = count_reg;
    if (clear_i) begin
      count_next = 32'h0000_0000;
    end else if (run_i) begin
      unique case (mode_i)
        clock_frequency_meter_pkg::MODE_FREQUENCY: begin
          // measured clock edges inside the reference window
          if (meas_rise_i) begin
            count_next = count_reg + 32'h0000_0001;
          end
        end
        clock_frequency_meter_pkg::MODE_TIME: begin
          // reference edges while the external enable is active
          if (ref_rise_i && time_en_i) begin
            count_next = count_reg + 32'h0000_0001;
          end
        end
        clock_frequency_meter_pkg::MODE_DISABLED,
        clock_frequency_meter_pkg::MODE_RESERVED: begin
          count_next = count_reg; // stays at the cleared zero
        end
      endcase
    end
  end

  // register the count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 32'h0000_0000;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule

// ===== test/clock_frequency_meter_chk.sv
/*
  Port checker for the clock frequency meter: register port handshake,
  refusals, start/busy sequencing and the monitor output gate.
  Assumes it is bound to the meter top and sees only its ports.
*/
`timescale 1ns/1ps
module clock_frequency_meter_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        single_cycle_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // status
  input wire logic        monitor_clk_o,
  input wire logic        busy_o
);
  localparam logic [11:0] CTRL = clock_frequency_meter_pkg::ADDR_MEAS_CONTROL;
  logic take;         // access taken at this edge
  logic bad_addr;     // outside the map or misaligned
  logic mon_en_reg;   // monitor enable as last written
  logic mon_en_next;
  assign take     = psel_i && (penable_i || single_cycle_i) && !pready_o;
  assign bad_addr = (paddr_i > 12'h02C) || (paddr_i[1:0] != 2'h0);
  // shadow of the enable bit, only byte lane 1 carries it
  always_comb begin
    mon_en_next = mon_en_reg;
    if (take && pwrite_i && !bad_addr && paddr_i == 12'h000 && pstrb_i[1]) begin
      mon_en_next = pwdata_i[11];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) mon_en_reg <= 1'b0;
    else mon_en_reg <= mon_en_next;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  pready_time_a: assert property (take |=> pready_o) else $error("access not answered");
  slverr_pair_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  unmapped_read_a: assert property (take && !pwrite_i && bad_addr |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  start_busy_a: assert property (take && pwrite_i && paddr_i == CTRL && pstrb_i[0] && pwdata_i[0] |=> busy_o)
    else $error("start not taken");
  idle_stays_a: assert property (!busy_o && !(take && pwrite_i && paddr_i == CTRL) |=> !busy_o)
    else $error("busy without start");
  busy_min_a: assert property ($rose(busy_o) |-> busy_o [*2]) else $error("run too short");
  status_read_a: assert property (take && !pwrite_i && paddr_i == CTRL ##1 $stable(busy_o) |-> prdata_o[0] == busy_o)
    else $error("start bit read wrong");
  monitor_off_a: assert property (!mon_en_reg [*4] |-> !monitor_clk_o) else $error("monitor not gated");
  done_cv: cover property ($fell(busy_o));
  refuse_cv: cover property (pslverr_o);
  monitor_cv: cover property ($rose(monitor_clk_o));
endmodule

// ===== test/clock_frequency_meter_test.sv
/*
  Self-checking bench for the clock frequency meter.
  Assumes measured and reference clocks may be divided from the bench clock.
*/
`timescale 1ns/1ps
module clock_frequency_meter_test;
  localparam logic [11:0] CS   = clock_frequency_meter_pkg::ADDR_CLOCK_SELECT;
  localparam logic [11:0] RL   = clock_frequency_meter_pkg::ADDR_RUN_LENGTH;
  localparam logic [11:0] MD   = clock_frequency_meter_pkg::ADDR_CHANNEL_MODE;
  localparam logic [11:0] CTRL = clock_frequency_meter_pkg::ADDR_MEAS_CONTROL;
  // design ports
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, single_cycle_i, pready_o, pslverr_o;
  logic        tck_i, pll_ref_i, time_enable_i, monitor_clk_o, busy_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, lfsr_reg;
  logic [3:0]  pstrb_i;
  logic [63:0] meas_clk_i;
  logic [7:0]  div;         // divider for all slow clocks
  typedef struct {string what; logic [31:0] exp; int tol; logic err; logic rd;} note_s;
  note_s       notes[$];    // one per access, oldest first
  int          err_total, checks_done;
  clock_frequency_meter u_clock_frequency_meter (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .single_cycle_i, .prdata_o, .pready_o, .pslverr_o, .meas_clk_i, .tck_i,
    .pll_ref_i, .time_enable_i, .monitor_clk_o, .busy_o);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // group g channel c runs at 40 ns shifted by (c+g)%3, references 320 and 160 ns
  always @(negedge clk_i) div <= div + 8'h01;
  always_comb for (int i = 0; i < 64; i++) meas_clk_i[i] = div[2 + (i / 8 + i % 8) % 3];
  assign tck_i     = div[5];
  assign pll_ref_i = div[4];
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic close_out;
    $display("Comparisons %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a tolerance absorbs the sampling lag of asynchronous clocks
  task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] s, input int tol);
    checks_done++;
    if (^s === 1'bx || s > e + tol || s + tol < e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, e, s);
    end
  endtask
  // results are taken off the queue in the cycle ready stands
  always @(negedge clk_i) if (pready_o === 1'b1) begin
    note_s n;
    if (notes.size() == 0) cmp_val("spare answer", 32'h0, 32'h1, 0);
    else begin
      n = notes.pop_front();
      cmp_val({n.what, " err"}, {31'h0, n.err}, {31'h0, pslverr_o}, 0);
      if (n.rd) cmp_val(n.what, n.exp, prdata_o, n.tol);
    end
  end
  // one access; request held until the edge that samples ready
  task automatic bus(input logic wr, input logic sc, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input string what, input logic [31:0] e, input int tol, input logic er);
    int n;
    notes.push_back('{what, e, tol, er, !wr});
    @(negedge clk_i);
    psel_i = 1'b1; pwrite_i = wr; paddr_i = a; pwdata_i = d; pstrb_i = s; single_cycle_i = sc;
    if (!sc) begin
      @(negedge clk_i);
      penable_i = 1'b1;
    end
    for (n = 0; n < 20 && pready_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 20) begin
      cmp_val("ready", 32'h1, 32'h0, 0);
      close_out();
    end
    @(negedge clk_i);
    psel_i = 1'b0; penable_i = 1'b0; single_cycle_i = 1'b0;
  endtask
  task automatic meas(input logic [2:0] g, input logic rf, input logic [31:0] rl, input logic te,
                      input logic [15:0] md);
    logic [31:0] e;
    int          r, t, n;
    bus(1, 0, CS, {27'h0, rf, 1'b0, g}, 4'hF, "select", 0, 0, 0);
    bus(1, 0, RL, rl, 4'hF, "length", 0, 0, 0);
    bus(1, 0, MD, {16'h0, md}, 4'hF, "mode", 0, 0, 0);
    time_enable_i = te;
    bus(1, 0, CTRL, 32'h1, 4'h1, "start", 0, 0, 0);
    bus(1, 0, RL, rl + 32'h64, 4'hF, "length busy", 0, 0, 0);
    bus(1, 0, CTRL, 32'h1, 4'h1, "start busy", 0, 0, 0);
    for (n = 0; n < 4000 && busy_o !== 1'b0; n++) @(negedge clk_i);
    if (n == 4000) begin
      cmp_val("busy", 32'h0, 32'h1, 0);
      close_out();
    end
    bus(0, 0, CTRL, 0, 4'hF, "control", 32'h0, 0, 0);
    for (int c = 0; c < 8; c++) begin
      r = (rf ? 160 : 320) / (40 << ((c + g) % 3));
      e = 32'h0;
      t = 0;
      if (md[2*c+:2] == clock_frequency_meter_pkg::MODE_FREQUENCY && clock_frequency_meter_pkg::IMPL_MASK_DEFAULT[g*8+c]) begin
        e = rl * r;
        t = r + 2;
      end
      if (md[2*c+:2] == clock_frequency_meter_pkg::MODE_TIME && te) begin
        e = rl;
        t = 1;
      end
      bus(0, 0, 12'h010 + 12'(4 * c), 0, 4'hF, "count", e, t, 0);
    end
  endtask
  // monitor edges over one 320 ns span
  task automatic mon(input logic [31:0] sel, input int e);
    logic [31:0] k;
    logic        last;
    bus(1, 0, CS, sel, 4'hF, "select", 0, 0, 0);
    repeat (8) @(negedge clk_i);
    k = 32'h0;
    last = monitor_clk_o;
    repeat (64) begin
      @(negedge clk_i);
      if (monitor_clk_o !== last) k++;
      last = monitor_clk_o;
    end
    cmp_val("monitor", e, k, e == 0 ? 0 : 2);
  endtask
  initial begin
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; single_cycle_i = 1'b0; div = 8'h00;
    paddr_i = 12'h000; pwdata_i = 32'h0; pstrb_i = 4'h0; time_enable_i = 1'b0; lfsr_reg = 32'h0000_0051;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    bus(0, 0, CS, 0, 4'hF, "select", 32'h0, 0, 0);
    bus(0, 0, RL, 0, 4'hF, "length", 32'h2710, 0, 0);
    bus(0, 0, MD, 0, 4'hF, "mode", 32'h0, 0, 0);
    bus(0, 0, CTRL, 0, 4'hF, "control", 32'h0, 0, 0);
    bus(1, 1, CS, 32'hFFFF_FFFF, 4'h1, "byte", 0, 0, 0);
    lfsr_reg = lfsr(lfsr_reg);
    bus(1, 0, CS, lfsr_reg, 4'h2, "byte", 0, 0, 0);
    bus(0, 1, CS, 0, 4'hF, "select", 32'h17 | (lfsr_reg & 32'hF00), 0, 0);
    lfsr_reg = lfsr(lfsr_reg);
    bus(1, 0, RL, lfsr_reg, 4'hF, "length", 0, 0, 0);
    bus(0, 0, RL, 0, 4'hF, "length", lfsr_reg, 0, 0);
    bus(0, 0, 12'h100, 0, 4'hF, "unmapped", 32'h0, 0, 1);
    bus(1, 0, 12'h005, 32'hFF, 4'hF, "misaligned", 0, 0, 1);
    meas(3'h1, clock_frequency_meter_pkg::REF_TCK, 32'h4, 1'b1, 16'h552D);
    meas(3'h2, clock_frequency_meter_pkg::REF_PLL, 32'h3, 1'b0, 16'h0197);
    mon(32'h0000_0801, 8);
    mon(32'h0000_0901, 4);
    mon(32'h0000_0101, 0);
    close_out();
  end
endmodule
bind clock_frequency_meter clock_frequency_meter_chk u_clock_frequency_meter_chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .single_cycle_i, .prdata_o, .pready_o, .pslverr_o,
  .monitor_clk_o, .busy_o);
